// ---- ocg_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module ocg_top
  import ocg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // oscillator monitor levels, asynchronous
  input  wire logic [3:0]  osc_stable_i,
  input  wire logic        fast_ext_osc_run_failure_i,
  input  wire logic        slow_ext_osc_run_failure_i,
  input  wire logic        fast_ext_osc_startup_failure_i,
  input  wire logic        slow_ext_osc_startup_failure_i,
  // gate enables
  output logic [15:0]      ahb_gate_cfg_o,
  output logic [15:0]      ahb_gate_work_o,
  output logic [15:0]      apb_gate_cfg_o,
  output logic [15:0]      apb_gate_work_o,
  // interrupts
  output logic             clk_ctrl_irq_o,
  output logic             fault_irq_o,
  output logic             irq_o
);

  // osc_stable_i: [3] slow ext, [2] slow int, [1] fast ext, [0] fast int
  logic [7:0]  sync1_r;
  logic [7:0]  sync2_r;
  logic [7:0]  sync_in;
  logic [3:0]  stab_prev_r;
  logic [1:0]  run_prev_r;
  logic [1:0]  start_prev_r;
  logic [8:0]  flags_r;
  logic [8:0]  flags_nxt;
  logic [8:0]  flag_set;
  logic [8:0]  flag_clr;
  logic [8:0]  irq_en_r;
  logic [2:0]  int_stat_r;
  logic [2:0]  int_mask_r;
  logic [2:0]  int_evt;
  logic [15:0] ahb_en_r;
  logic [15:0] apb_en_r;
  logic        acc_r;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_nxt;
  logic [31:0] flag_word;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == OFS_FLAGS) || (a == OFS_FLAG_CLEAR) || (a == OFS_IRQ_ENABLE) ||
          (a == OFS_AHB_GATES) || (a == OFS_APB_GATES) ||
          (a == OFS_IRQ_STATUS) || (a == OFS_IRQ_MASK);
  endfunction

  // two-flop synchronisers; only the second stage is read
  assign sync_in = {2'h0, slow_ext_osc_startup_failure_i, fast_ext_osc_startup_failure_i,
                    osc_stable_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 8'h01;
      sync2_r <= 8'h01;
    end else begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
    end
  end

  // run failure inputs share the same two-stage treatment
  logic [1:0] rf1_r;
  logic [1:0] rf2_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rf1_r <= 2'h0;
      rf2_r <= 2'h0;
    end else begin
      rf1_r <= {fast_ext_osc_run_failure_i, slow_ext_osc_run_failure_i};
      rf2_r <= rf1_r;
    end
  end

  // edge history for latching events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stab_prev_r  <= 4'h1;
      run_prev_r   <= 2'h0;
      start_prev_r <= 2'h0;
    end else begin
      stab_prev_r  <= sync2_r[3:0];
      run_prev_r   <= rf2_r;
      start_prev_r <= sync2_r[5:4];
    end
  end

  // bus handshake: one wait cycle, then answer
  assign wr_go = avs_write_i && acc_r;
  assign rd_go = avs_read_i && acc_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= 1'b0;
    end else begin
      acc_r <= (avs_read_i || avs_write_i) && !acc_r;
    end
  end
  assign avs_waitrequest_o = !acc_r;

  // flag sources
  always_comb begin
    flag_set    = 9'h000;
    flag_set[0] = sync2_r[0] && !stab_prev_r[0];
    flag_set[1] = sync2_r[1] && !stab_prev_r[1];
    flag_set[3] = sync2_r[2] && !stab_prev_r[2];
    flag_set[4] = sync2_r[3] && !stab_prev_r[3];
    flag_set[5] = sync2_r[5] && !start_prev_r[1];
    flag_set[6] = sync2_r[4] && !start_prev_r[0];
    flag_set[7] = rf2_r[0] && !run_prev_r[0];
    flag_set[8] = rf2_r[1] && !run_prev_r[1];
  end

  // write zero clears, byte lanes honoured
  always_comb begin
    flag_clr = 9'h000;
    if (wr_go && avs_address_i == OFS_FLAG_CLEAR) begin
      flag_clr[7:0] = avs_byteenable_i[0] ? ~avs_writedata_i[7:0] : 8'h00;
      flag_clr[8]   = avs_byteenable_i[1] && !avs_writedata_i[8];
      flag_clr      = flag_clr & CLR_MASK;
    end
  end

  // set wins over a clear in the same cycle
  assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

  // flags reset with fast internal ready set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= RST_FLAGS[8:0];
    end else begin
      flags_r <= flags_nxt & CLR_MASK;
    end
  end

  // stable bits are live, read only
  always_comb begin
    flag_word                      = {23'h0, flags_r};
    flag_word[POS_SLOW_EXT_STABLE] = sync2_r[3];
    flag_word[POS_SLOW_INT_STABLE] = sync2_r[2];
    flag_word[POS_FAST_EXT_STABLE] = sync2_r[1];
    flag_word[POS_FAST_INT_STABLE] = sync2_r[0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ahb_en_r <= RST_GATES[15:0];
      apb_en_r <= RST_GATES[15:0];
      irq_en_r <= 9'h000;
      int_mask_r <= 3'h0;
    end else if (wr_go) begin
      if (avs_address_i == OFS_AHB_GATES) begin
        if (avs_byteenable_i[0]) ahb_en_r[7:0] <= avs_writedata_i[7:0] & AHB_MASK[7:0];
        if (avs_byteenable_i[1]) ahb_en_r[15:8] <= avs_writedata_i[15:8] & AHB_MASK[15:8];
      end
      if (avs_address_i == OFS_APB_GATES) begin
        if (avs_byteenable_i[0]) apb_en_r[7:0] <= avs_writedata_i[7:0] & APB_MASK[7:0];
        if (avs_byteenable_i[1]) apb_en_r[15:8] <= avs_writedata_i[15:8] & APB_MASK[15:8];
      end
      if (avs_address_i == OFS_IRQ_ENABLE && (&avs_byteenable_i[1:0])) begin
        irq_en_r <= avs_writedata_i[8:0] & CLR_MASK;
      end
      if (avs_address_i == OFS_IRQ_MASK && avs_byteenable_i[0]) begin
        int_mask_r <= avs_writedata_i[2:0] & EVT_MASK_BITS;
      end
    end
  end

  // enables change on the register clock only; the peripheral clock
  // gate cells latch them while their clock is low, which avoids runt pulses
  // both clocks for ports, checksum and dma
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ahb_gate_cfg_o  <= RST_GATES[15:0];
      ahb_gate_work_o <= RST_GATES[15:0];
      apb_gate_cfg_o  <= RST_GATES[15:0];
      apb_gate_work_o <= RST_GATES[15:0];
    end else begin
      ahb_gate_cfg_o  <= ahb_en_r;
      ahb_gate_work_o <= ahb_en_r & 16'h02f5;
      apb_gate_cfg_o  <= apb_en_r;
      apb_gate_work_o <= apb_en_r & 16'hb856;
    end
  end

  // run failures to the fault line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_ctrl_irq_o <= 1'b0;
      fault_irq_o    <= 1'b0;
    end else begin
      clk_ctrl_irq_o <= |(flags_nxt & irq_en_r & ~FAULT_MASK);
      fault_irq_o    <= |(flags_nxt & irq_en_r & FAULT_MASK);
    end
  end

  // sticky event status, write one to clear, set wins
  always_comb begin
    int_evt                = 3'h0;
    int_evt[EVT_FLAG_SET]  = |(flag_set & ~FAULT_MASK);
    int_evt[EVT_FAULT_SET] = |(flag_set & FAULT_MASK);
    int_evt[EVT_BAD_ADDR]  = (wr_go || rd_go) && !hit(avs_address_i);
  end
  logic [2:0] int_clr;
  assign int_clr = (wr_go && avs_address_i == OFS_IRQ_STATUS && avs_byteenable_i[0]) ?
                   avs_writedata_i[2:0] : 3'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_r <= 3'h0;
    end else begin
      int_stat_r <= (int_stat_r & ~int_clr) | int_evt;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((int_stat_r & ~int_clr) | int_evt) & int_mask_r);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_nxt = 32'h0;
    unique case (avs_address_i)
      OFS_FLAGS:      rd_nxt = flag_word;
      OFS_FLAG_CLEAR: rd_nxt = RST_FLAG_CLEAR;
      OFS_IRQ_ENABLE: rd_nxt = {23'h0, irq_en_r};
      OFS_AHB_GATES:  rd_nxt = {16'h0, ahb_en_r};
      OFS_APB_GATES:  rd_nxt = {16'h0, apb_en_r};
      OFS_IRQ_STATUS: rd_nxt = {29'h0, int_stat_r};
      OFS_IRQ_MASK:   rd_nxt = {29'h0, int_mask_r};
      default:        rd_nxt = 32'h0;
    endcase
  end
  // read data register loads during the wait cycle, stands at the answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && !acc_r) begin
      avs_readdata_o <= rd_nxt;
    end
  end

  AST_FLAGS_RESET: assert property (@(posedge clk_i) $fell(rst_i) |-> flags_r == RST_FLAGS[8:0])
    else $error("flags not at reset value");
  // fast run failure edge sets bit 8 next cycle
  AST_FAST_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
    (rf2_r[1] && !run_prev_r[1]) |=> flags_r[8])
    else $error("fast run failure not latched");
  // slow run failure sets bit 7
  AST_SLOW_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
    (rf2_r[0] && !run_prev_r[0]) |=> flags_r[7])
    else $error("slow run failure not latched");
  AST_START_FAIL: assert property (@(posedge clk_i) disable iff (rst_i)
    (sync2_r[4] && !start_prev_r[0]) |=> flags_r[6])
    else $error("start failure not latched");
  AST_READY_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags_r[1] && !flag_clr[1]) |=> flags_r[1])
    else $error("ready flag dropped");
  AST_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_clr[3] && !flag_set[3]) |=> !flags_r[3])
    else $error("flag not cleared");
  AST_STABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_word[POS_FAST_EXT_STABLE] == $past(osc_stable_i[1], 2))
    else $error("stable bit mismatch");
  // written ahb enable reaches the gate two edges later
  AST_AHB_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && avs_address_i == OFS_AHB_GATES && avs_byteenable_i[0])
    |=> ##1 ahb_gate_cfg_o[0] == $past(avs_writedata_i[0], 2))
    else $error("ahb gate not applied");
  // config-only apb bits 8 and 3 never drive a work clock
  AST_APB_CFG_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    !apb_gate_work_o[8] && !apb_gate_work_o[3])
    else $error("config-only bit on work clock");
  // fault line follows a fast run failure whose enable stood an edge
  AST_FAULT_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags_r[8] && irq_en_r[8] && $past(irq_en_r[8])) |-> fault_irq_o)
    else $error("fault line low");
  AST_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i)
    (apb_en_r & ~APB_MASK) == 16'h0)
    else $error("reserved bit set");
  // a new enabled flag raises the general line one edge later
  sequence seq_gen_flag_set;
    |(flag_set & irq_en_r & ~FAULT_MASK);
  endsequence
  AST_GEN_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_gen_flag_set |=> clk_ctrl_irq_o)
    else $error("general interrupt line low");
  // run failures alone never raise the general line
  AST_GEN_NO_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
    ((flags_r & ~FAULT_MASK) == 9'h000) |-> !clk_ctrl_irq_o)
    else $error("general line raised by fault flag");
  // clear register read is fixed; data loads in the wait cycle
  sequence seq_clear_reg_read;
    avs_read_i && !acc_r && avs_address_i == OFS_FLAG_CLEAR;
  endsequence
  AST_CLEAR_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_clear_reg_read |=> avs_readdata_o == RST_FLAG_CLEAR)
    else $error("clear register readback wrong");
  // ahb enables are zero after reset
  AST_AHB_RESET: assert property (@(posedge clk_i)
    $fell(rst_i) |-> ahb_en_r == RST_GATES[15:0])
    else $error("ahb enables not zero after reset");
  // apb enables are zero after reset
  AST_APB_RESET: assert property (@(posedge clk_i)
    $fell(rst_i) |-> apb_en_r == RST_GATES[15:0])
    else $error("apb enables not zero after reset");
  // both-clock ahb bits drive the work clock with the config clock
  AST_AHB_BOTH: assert property (@(posedge clk_i) disable iff (rst_i)
    (ahb_gate_work_o & 16'h02f5) == (ahb_gate_cfg_o & 16'h02f5))
    else $error("ahb work clock differs from config clock");
  // program memory bit never opens a work clock
  AST_AHB_CFG_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    !ahb_gate_work_o[1])
    else $error("program memory work clock enabled");
  // both-clock apb bits drive the work clock with the config clock
  AST_APB_BOTH: assert property (@(posedge clk_i) disable iff (rst_i)
    (apb_gate_work_o & 16'hb856) == (apb_gate_cfg_o & 16'hb856))
    else $error("apb work clock differs from config clock");
  // gate enables move only one register edge after the register
  AST_GATE_LAG: assert property (@(posedge clk_i) disable iff (rst_i)
    ahb_gate_cfg_o == $past(ahb_en_r) && apb_gate_cfg_o == $past(apb_en_r))
    else $error("gate enable moved off the register edge");

endmodule
`default_nettype wire

// ---- ocg_pkg.sv ----
package ocg_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_FLAGS      = 8'h10;
  localparam logic [7:0]  OFS_FLAG_CLEAR = 8'h14;
  localparam logic [7:0]  OFS_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0]  OFS_AHB_GATES  = 8'h30;
  localparam logic [7:0]  OFS_APB_GATES  = 8'h38;
  localparam logic [7:0]  OFS_IRQ_STATUS = 8'h50;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h54;
  // reset values
  localparam logic [31:0] RST_FLAGS      = 32'h0000_0801;
  localparam logic [31:0] RST_FLAG_CLEAR = 32'h0000_01ff;
  localparam logic [31:0] RST_GATES      = 32'h0000_0000;
  // implemented bit masks
  localparam logic [8:0]  CLR_MASK       = 9'h1fb;
  localparam logic [15:0] AHB_MASK       = 16'h02f7;
  localparam logic [15:0] APB_MASK       = 16'hb9fe;
  localparam logic [8:0]  FAULT_MASK     = 9'h180;
  // stable status bit positions
  localparam int          POS_SLOW_EXT_STABLE = 15;
  localparam int          POS_SLOW_INT_STABLE = 14;
  localparam int          POS_FAST_EXT_STABLE = 12;
  localparam int          POS_FAST_INT_STABLE = 11;
  // own interrupt status layout
  localparam int          EVT_FLAG_SET   = 0;
  localparam int          EVT_FAULT_SET  = 1;
  localparam int          EVT_BAD_ADDR   = 2;
  localparam logic [2:0]  EVT_MASK_BITS  = 3'h7;
endpackage

// ---- test_osc_status_and_clock_gating.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_osc_status_and_clock_gating;
  import ocg_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0]  ben = 4'hf;
  logic [31:0] rdat;
  logic        wreq;
  logic [3:0]  stab = 4'h1;
  logic        fe_run = 1'b0;
  logic        se_run = 1'b0;
  logic        fe_start = 1'b0;
  logic        se_start = 1'b0;
  logic [15:0] ahb_cfg, ahb_work, apb_cfg, apb_work;
  logic        cc_irq, flt_irq, own_irq;
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc = 0;

  ocg_top dut_u (
    .clk_i                          (clk_i),
    .rst_i                          (rst_i),
    .avs_address_i                  (adr),
    .avs_read_i                     (rd),
    .avs_write_i                    (wr),
    .avs_writedata_i                (wdat),
    .avs_byteenable_i               (ben),
    .avs_readdata_o                 (rdat),
    .avs_waitrequest_o              (wreq),
    .osc_stable_i                   (stab),
    .fast_ext_osc_run_failure_i     (fe_run),
    .slow_ext_osc_run_failure_i     (se_run),
    .fast_ext_osc_startup_failure_i (fe_start),
    .slow_ext_osc_startup_failure_i (se_start),
    .ahb_gate_cfg_o                 (ahb_cfg),
    .ahb_gate_work_o                (ahb_work),
    .apb_gate_cfg_o                 (apb_cfg),
    .apb_gate_work_o                (apb_work),
    .clk_ctrl_irq_o                 (cc_irq),
    .fault_irq_o                    (flt_irq),
    .irq_o                          (own_irq)
  );

  // 125 MHz system clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // hang guard, well above the fewer than two hundred cycles the tests take
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    adr  <= a;
    wdat <= d;
    rd   <= ~we;
    wr   <= we;
    @(posedge clk_i);
    while (wreq !== 1'b0) begin
      @(posedge clk_i);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    // idle edge so the next call never re-raises in this time step
    @(posedge clk_i);
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // main sequence
  initial begin
    idle(4);
    rst_i <= 1'b0;
    idle(1);
    rd_chk(OFS_FLAGS, 32'h0000_0801);
    rd_chk(OFS_FLAG_CLEAR, 32'h0000_01ff);
    rd_chk(OFS_AHB_GATES, 32'h0000_0000);
    rd_chk(OFS_APB_GATES, 32'h0000_0000);
    $display("test reset values done");

    // stable levels are live, ready flags latch, writes ignored
    wr32(OFS_IRQ_ENABLE, 32'h0000_0180);
    stab <= 4'hf;
    idle(8);
    rd_chk(OFS_FLAGS, 32'h0000_d81b);
    wr32(OFS_FLAGS, 32'h0000_d9fb);
    rd_chk(OFS_FLAGS, 32'h0000_d81b);
    chk({30'h0, flt_irq, cc_irq}, 32'h0);
    $display("test stable and ready done");

    // run failures go to the fault line only
    fe_run <= 1'b1;
    se_run <= 1'b1;
    idle(8);
    rd_chk(OFS_FLAGS, 32'h0000_d99b);
    chk({30'h0, flt_irq, cc_irq}, 32'h2);
    wr32(OFS_IRQ_ENABLE, 32'h0000_01fb);
    fe_start <= 1'b1;
    se_start <= 1'b1;
    idle(8);
    rd_chk(OFS_FLAGS, 32'h0000_d9fb);
    chk({30'h0, flt_irq, cc_irq}, 32'h3);
    $display("test failure flags done");

    // zero clears a flag, one leaves it
    fe_run <= 1'b0;
    se_run <= 1'b0;
    fe_start <= 1'b0;
    se_start <= 1'b0;
    wr32(OFS_FLAG_CLEAR, 32'h0000_00ff);
    rd_chk(OFS_FLAGS, 32'h0000_d8fb);
    rd_chk(OFS_FLAG_CLEAR, 32'h0000_01ff);
    wr32(OFS_FLAG_CLEAR, 32'h0000_0004);
    rd_chk(OFS_FLAGS, 32'h0000_d800);
    idle(3);
    chk({30'h0, flt_irq, cc_irq}, 32'h0);
    stab <= 4'h0;
    idle(8);
    rd_chk(OFS_FLAGS, 32'h0000_0000);
    $display("test flag clear done");

    // gate registers: implemented bits read back, config versus work split
    wr32(OFS_AHB_GATES, 32'h0000_02f7);
    wr32(OFS_APB_GATES, 32'h0000_b9fe);
    rd_chk(OFS_AHB_GATES, 32'h0000_02f7);
    rd_chk(OFS_APB_GATES, 32'h0000_b9fe);
    idle(2);
    chk({16'h0, ahb_cfg}, 32'h0000_02f7);
    chk({16'h0, ahb_work}, 32'h0000_02f5);
    chk({16'h0, apb_cfg}, 32'h0000_b9fe);
    chk({16'h0, apb_work}, 32'h0000_b856);
    wr32(OFS_AHB_GATES, 32'h0000_0000);
    wr32(OFS_APB_GATES, 32'h0000_0000);
    idle(2);
    chk({ahb_cfg, apb_cfg}, 32'h0000_0000);
    // only the low byte lane lands
    ben <= 4'h1;
    wr32(OFS_AHB_GATES, 32'h0000_02f7);
    ben <= 4'hf;
    rd_chk(OFS_AHB_GATES, 32'h0000_00f7);
    $display("test clock gates done");

    // own status: bad address event, mask, write-one clear
    wr32(OFS_IRQ_STATUS, 32'h0000_0007);
    wr32(OFS_IRQ_MASK, 32'h0000_0004);
    rd_chk(8'hfc, 32'h0000_0000);
    idle(2);
    chk({31'h0, own_irq}, 32'h1);
    wr32(OFS_IRQ_STATUS, 32'h0000_0004);
    idle(2);
    chk({31'h0, own_irq}, 32'h0);
    $display("test own interrupt done");
    wrap_up();
  end
endmodule
`default_nettype wire
